// file: verilog/ppm_seq.sv
/*
  ppm_seq: reset, standby, normal and sleep sequencer of a single-pair PHY.
  Assumes the management frame decoder outside presents decoded register
  accesses as one-cycle strobes, and that pins other than wake are synchronous.
*/
// Operation
// - reset on power-up, long pin pulse, bit
// - reset restarts fsm, registers to defaults
// - reference clock output stays on in reset while supply is ok
// - line termination off during reset
// - straps relatched by pin, low-supply and wake resets, not by the bit
// - managed strap enters standby after reset, unless woken from sleep
// - standby: pcs/pma off, management alive
// - autonomous strap goes straight to normal
// - autonomous normal attempts link automatically
// - mode bit 6 selects autonomous operation
// - command 0x001 moves standby to normal
// - command 0x0010 returns normal to standby
// - sleep: all off but energy detect and supply inhibit, registers lost, no access
// - master never sleeps by partner action
// - slave with bit7 sleeps on energy loss
// - inhibit supplies, sleep only once removed
// - wake pin high exits sleep
// - low supply: outputs high impedance outside sleep request and sleep, analog off
module ppm_seq #(
  parameter int unsigned WAKE_PAT_CYC = ppm_pkg::WAKE_PAT_CYC,
  parameter int unsigned EN_LOSS_CYC  = ppm_pkg::EN_LOSS_CYC
) (
  input  wire logic        i_mclk,
  input  wire logic        i_arst_n,
  input  wire logic        i_rst_pin_n,
  input  wire logic        i_supply_ok,
  input  wire logic        i_supply_off,
  input  wire logic        i_wake,
  input  wire logic        i_energy_det,
  input  wire logic        i_strap_auto,
  input  wire logic        i_strap_master,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [15:0] i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  output logic      [15:0] o_reg_rdata,
  output logic             o_reg_ack,
  output logic             o_clkout_en,
  output logic             o_pma_term_en,
  output logic             o_pcs_en,
  output logic             o_pma_en,
  output logic             o_link_en,
  output logic             o_smi_en,
  output logic             o_supply_inhibit_out,
  output logic             o_io_hiz,
  output logic             o_analog_en,
  output logic             o_energy_det_en,
  output logic      [4:0]  o_state
);
  ppm_pkg::ppm_state_e state_q, state_d;
  logic [7:0]  hold_q, hold_d;
  logic        relatch_q, relatch_d;
  logic        wakeup_q, wakeup_d;
  logic        strap_auto_q, strap_auto_d;
  logic        strap_master_q, strap_master_d;
  logic [15:0] mode_q, mode_d;
  logic        wake_s;
  logic        pin_rst_held;
  logic        en_lost_held;
  logic        en_seen_held;
  logic        acc_ok;
  logic        wr_swrst;
  logic        wr_cmd_normal;
  logic        wr_cmd_standby;
  logic        local_sleep;
  logic        remote_sleep;
  logic [15:0] rdata_d;

  ppm_sync2 u_wake_sync (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_d      (i_wake),
    .o_q      (wake_s)
  );

  ppm_persist #(.LIMIT(16'(ppm_pkg::RST_PULSE_CYC))) u_pin_rst (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_level  (!i_rst_pin_n),
    .o_held   (pin_rst_held)
  );

  ppm_persist #(.LIMIT(16'(EN_LOSS_CYC))) u_en_loss (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_level  (!i_energy_det),
    .o_held   (en_lost_held)
  );

  // partner patterns are only recognised once sustained, so line noise cannot wake us
  ppm_persist #(.LIMIT(16'(WAKE_PAT_CYC))) u_en_seen (
    .i_mclk   (i_mclk),
    .i_arst_n (i_arst_n),
    .i_level  (i_energy_det),
    .o_held   (en_seen_held)
  );

  always_comb begin
    // the cycle that drops into sleep takes no access, so no answer can land in sleep
    acc_ok         = (state_q == ppm_pkg::ST_STANDBY) || (state_q == ppm_pkg::ST_NORMAL) ||
                     ((state_q == ppm_pkg::ST_SLP_REQ) && !i_supply_off);
    wr_swrst       = acc_ok && i_reg_wr && (i_reg_addr == ppm_pkg::REG_SWRST_ADDR) &&
                     i_reg_wdata[ppm_pkg::SWRST_BIT];
    wr_cmd_normal  = acc_ok && i_reg_wr && (i_reg_addr == ppm_pkg::REG_CMD_ADDR) &&
                     (i_reg_wdata == ppm_pkg::CMD_GO_NORMAL);
    wr_cmd_standby = acc_ok && i_reg_wr && (i_reg_addr == ppm_pkg::REG_CMD_ADDR) &&
                     (i_reg_wdata == ppm_pkg::CMD_GO_STANDBY);
    // master: bit7 and wake low; slave additionally needs bit8 cleared
    local_sleep    = mode_q[ppm_pkg::MODE_SLEEP_BIT] && !wake_s &&
                     (strap_master_q || !mode_q[ppm_pkg::MODE_SBLK_BIT]);
    // only a slave listens to the line for sleep; a master ignores the partner
    remote_sleep   = !strap_master_q && mode_q[ppm_pkg::MODE_SLEEP_BIT] && en_lost_held;
  end

  always_comb begin
    state_d        = state_q;
    hold_d         = hold_q;
    relatch_d      = relatch_q;
    wakeup_d       = wakeup_q;
    strap_auto_d   = strap_auto_q;
    strap_master_d = strap_master_q;
    mode_d         = mode_q;
    if (acc_ok && i_reg_wr && (i_reg_addr == ppm_pkg::REG_MODE_ADDR)) begin
      mode_d = i_reg_wdata;
    end
    unique case (state_q)
      ppm_pkg::ST_RESET: begin
        mode_d = ppm_pkg::MODE_RST;
        mode_d[ppm_pkg::MODE_AUTO_BIT] = strap_auto_q;
        if (relatch_q) begin
          strap_auto_d   = i_strap_auto;
          strap_master_d = i_strap_master;
        end
        if (hold_q == 8'(ppm_pkg::RST_HOLD_CYC)) begin
          relatch_d = 1'b0;
          wakeup_d  = 1'b0;
          hold_d    = 8'h00;
          // managed strap parks in standby; autonomous or woken goes to normal
          state_d   = (strap_auto_q || wakeup_q) ? ppm_pkg::ST_NORMAL : ppm_pkg::ST_STANDBY;
        end else begin
          hold_d = hold_q + 8'h01;
        end
      end
      ppm_pkg::ST_STANDBY: begin
        if (wr_cmd_normal || mode_q[ppm_pkg::MODE_AUTO_BIT]) begin
          state_d = ppm_pkg::ST_NORMAL;
        end
      end
      ppm_pkg::ST_NORMAL: begin
        if (wr_cmd_standby) begin
          state_d = ppm_pkg::ST_STANDBY;
        end else if (local_sleep || remote_sleep) begin
          state_d = ppm_pkg::ST_SLP_REQ;
        end
      end
      ppm_pkg::ST_SLP_REQ: begin
        if (i_supply_off) begin
          state_d = ppm_pkg::ST_SLEEP;
        end
      end
      ppm_pkg::ST_SLEEP: begin
        mode_d = ppm_pkg::MODE_RST;
        if (wake_s || en_seen_held) begin
          state_d   = ppm_pkg::ST_RESET;
          wakeup_d  = 1'b1;
          relatch_d = 1'b1;
          hold_d    = 8'h00;
        end
      end
      default: begin
        state_d = ppm_pkg::ST_RESET;
      end
    endcase
    // supply monitor is bypassed while the sequencer itself removes the supplies
    if (((!i_supply_ok) && (state_q != ppm_pkg::ST_SLP_REQ) && (state_q != ppm_pkg::ST_SLEEP)) ||
        pin_rst_held) begin
      state_d   = ppm_pkg::ST_RESET;
      relatch_d = 1'b1;
      wakeup_d  = 1'b0;
      hold_d    = 8'h00;
    end else if (wr_swrst) begin
      state_d = ppm_pkg::ST_RESET;
      hold_d  = 8'h00;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q        <= ppm_pkg::ST_RESET;
      hold_q         <= 8'h00;
      relatch_q      <= 1'b1;
      wakeup_q       <= 1'b0;
      strap_auto_q   <= 1'b0;
      strap_master_q <= 1'b0;
      mode_q         <= ppm_pkg::MODE_RST;
    end else begin
      state_q        <= state_d;
      hold_q         <= hold_d;
      relatch_q      <= relatch_d;
      wakeup_q       <= wakeup_d;
      strap_auto_q   <= strap_auto_d;
      strap_master_q <= strap_master_d;
      mode_q         <= mode_d;
    end
  end

  // register read path; the reset bit self-clears so it always reads zero
  always_comb begin
    rdata_d = 16'h0000;
    if (acc_ok && i_reg_rd) begin
      if (i_reg_addr == ppm_pkg::REG_MODE_ADDR) begin
        rdata_d = mode_q;
      end else if (i_reg_addr == ppm_pkg::REG_CMD_ADDR) begin
        rdata_d = {11'h000, state_q};
      end
    end
  end

  // enables decode the next state so each flop matches state_q in the same cycle; ack and read data follow the access
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata          <= 16'h0000;
      o_reg_ack            <= 1'b0;
      o_clkout_en          <= 1'b1;
      o_pma_term_en        <= 1'b0;
      o_pcs_en             <= 1'b0;
      o_pma_en             <= 1'b0;
      o_link_en            <= 1'b0;
      o_smi_en             <= 1'b0;
      o_supply_inhibit_out <= 1'b0;
      o_io_hiz             <= 1'b1;
      o_analog_en          <= 1'b0;
      o_energy_det_en      <= 1'b1;
      o_state              <= ppm_pkg::ST_RESET;
    end else begin
      o_reg_rdata          <= rdata_d;
      o_reg_ack            <= acc_ok && (i_reg_rd || i_reg_wr);
      o_clkout_en          <= (state_d != ppm_pkg::ST_SLEEP) && i_supply_ok;
      o_pma_term_en        <= (state_d == ppm_pkg::ST_NORMAL);
      o_pcs_en             <= (state_d == ppm_pkg::ST_NORMAL);
      o_pma_en             <= (state_d == ppm_pkg::ST_NORMAL);
      o_link_en            <= (state_d == ppm_pkg::ST_NORMAL);
      o_smi_en             <= (state_d == ppm_pkg::ST_STANDBY) || (state_d == ppm_pkg::ST_NORMAL) ||
                              (state_d == ppm_pkg::ST_SLP_REQ);
      o_supply_inhibit_out <= (state_d == ppm_pkg::ST_SLP_REQ) || (state_d == ppm_pkg::ST_SLEEP);
      o_io_hiz             <= !i_supply_ok && (state_d == ppm_pkg::ST_RESET);
      o_analog_en          <= i_supply_ok && (state_d != ppm_pkg::ST_SLEEP);
      o_energy_det_en      <= 1'b1;
      o_state              <= state_d;
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);

  pin_reset_a: assert property (pin_rst_held |=> state_q == ppm_pkg::ST_RESET && relatch_q)
    else $error("long reset pin pulse did not reset");
  sw_reset_a: assert property (wr_swrst && i_supply_ok && !pin_rst_held |=>
      state_q == ppm_pkg::ST_RESET && relatch_q == $past(relatch_q))
    else $error("register reset misbehaved");
  reg_default_a: assert property (state_q == ppm_pkg::ST_RESET && !acc_ok |=>
      mode_q[15:7] == ppm_pkg::MODE_RST[15:7])
    else $error("registers not defaulted in reset");
  clk_in_reset_a: assert property (state_q == ppm_pkg::ST_RESET && $past(i_supply_ok) |-> o_clkout_en)
    else $error("clock output stopped in reset");
  term_off_a: assert property (state_q == ppm_pkg::ST_RESET |-> !o_pma_term_en)
    else $error("termination on in reset");
  strap_hold_a: assert property (!relatch_q |=> $stable(strap_auto_q) && $stable(strap_master_q))
    else $error("straps changed without pin reset");
  managed_boot_a: assert property (state_q == ppm_pkg::ST_RESET && state_d == ppm_pkg::ST_STANDBY |->
      !strap_auto_q && !wakeup_q)
    else $error("standby entered with autonomous strap");
  standby_off_a: assert property (state_q == ppm_pkg::ST_STANDBY |->
      !o_pcs_en && !o_pma_en && !o_link_en && o_smi_en)
    else $error("standby outputs wrong");
  auto_boot_a: assert property (state_q == ppm_pkg::ST_RESET && strap_auto_q &&
      hold_q == 8'(ppm_pkg::RST_HOLD_CYC) && i_supply_ok && !pin_rst_held |=> o_link_en)
    else $error("autonomous strap did not reach normal");
  cmd_normal_a: assert property (state_q == ppm_pkg::ST_STANDBY && !mode_q[ppm_pkg::MODE_AUTO_BIT] &&
      !wr_cmd_normal |=> state_q != ppm_pkg::ST_NORMAL)
    else $error("left standby without command");
  cmd_standby_a: assert property (state_q == ppm_pkg::ST_NORMAL && wr_cmd_standby && i_supply_ok &&
      !pin_rst_held |=> state_q == ppm_pkg::ST_STANDBY && !o_pcs_en)
    else $error("standby command ignored");
  sleep_closed_a: assert property (state_q == ppm_pkg::ST_SLEEP |-> !o_smi_en && !o_reg_ack && !o_link_en)
    else $error("sleep left something on");
  master_awake_a: assert property (strap_master_q && wake_s && state_q == ppm_pkg::ST_NORMAL |=>
      state_q != ppm_pkg::ST_SLP_REQ)
    else $error("master slept by partner");
  slave_loss_a: assert property (state_q == ppm_pkg::ST_NORMAL && remote_sleep && !wr_cmd_standby &&
      !wr_swrst && i_supply_ok && !pin_rst_held |=> state_q == ppm_pkg::ST_SLP_REQ)
    else $error("slave ignored energy loss");
  inhibit_gate_a: assert property (state_q == ppm_pkg::ST_SLP_REQ && !i_supply_off && !pin_rst_held &&
      !wr_swrst |=> state_q == ppm_pkg::ST_SLP_REQ && o_supply_inhibit_out)
    else $error("sleep without supply removal");
  wake_exit_a: assert property (state_q == ppm_pkg::ST_SLEEP && wake_s |=> state_q == ppm_pkg::ST_RESET ##1
      state_q == ppm_pkg::ST_RESET)
    else $error("wake pin did not exit sleep");
  hiz_a: assert property (!$past(i_supply_ok) && state_q == ppm_pkg::ST_RESET |-> o_io_hiz && !o_analog_en)
    else $error("outputs not released on low supply");

  standby_to_normal_c: cover property (state_q == ppm_pkg::ST_STANDBY ##1 state_q == ppm_pkg::ST_NORMAL);
  normal_to_sleep_c: cover property (state_q == ppm_pkg::ST_SLP_REQ ##1 state_q == ppm_pkg::ST_SLEEP);
  remote_wake_c: cover property (state_q == ppm_pkg::ST_SLEEP && en_seen_held ##1 state_q == ppm_pkg::ST_RESET);
  sw_reset_c: cover property (wr_swrst ##1 state_q == ppm_pkg::ST_RESET);
endmodule // ppm_seq

// file: common/ppm_pkg.sv
/*
  ppm_pkg: constants and types shared by the power-mode sequencer.
  Assumes a 25 MHz core clock and 16-bit management registers.
*/
package ppm_pkg;

  localparam int unsigned CLK_PERIOD_NS = 40;

  // register addresses and field positions
  localparam logic [15:0] REG_SWRST_ADDR = 16'h001F;
  localparam logic [15:0] REG_MODE_ADDR  = 16'h018B;
  localparam logic [15:0] REG_CMD_ADDR   = 16'h018C;
  localparam int unsigned SWRST_BIT      = 15;
  localparam int unsigned MODE_AUTO_BIT  = 6;
  localparam int unsigned MODE_SLEEP_BIT = 7;
  localparam int unsigned MODE_SBLK_BIT  = 8;

  // command values and reset values
  localparam logic [15:0] CMD_GO_NORMAL  = 16'h0001;
  localparam logic [15:0] CMD_GO_STANDBY = 16'h0010;
  localparam logic [15:0] MODE_RST       = 16'h0100;

  // timing: least times round up
  localparam int unsigned RST_PULSE_NS   = 1000;
  localparam int unsigned RST_PULSE_CYC  = (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_HOLD_NS    = 1000;
  localparam int unsigned RST_HOLD_CYC   = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WAKE_PAT_US    = 1250;
  localparam int unsigned WAKE_PAT_CYC   = (WAKE_PAT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EN_LOSS_US     = 1250;
  localparam int unsigned EN_LOSS_CYC    = (EN_LOSS_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [4:0] {
    ST_RESET   = 5'h01,
    ST_STANDBY = 5'h02,
    ST_NORMAL  = 5'h04,
    ST_SLP_REQ = 5'h08,
    ST_SLEEP   = 5'h10
  } ppm_state_e;

endpackage

// file: verilog/ppm_sync2.sv
/*
  ppm_sync2: two-flop level synchroniser.
  Assumes the input is asynchronous to i_mclk; only the second flop is read.
*/
module ppm_sync2 (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_q;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta_q <= 1'b0;
      o_q    <= 1'b0;
    end else begin
      meta_q <= i_d;
      o_q    <= meta_q;
    end
  end
endmodule // ppm_sync2

// file: verilog/ppm_persist.sv
/*
  ppm_persist: raises o_held once i_level has been true for LIMIT consecutive cycles.
  Assumes i_level is synchronous to i_mclk; any false cycle restarts the count.
*/
module ppm_persist #(
  parameter logic [15:0] LIMIT = 16'h0001
) (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_level,
  output logic      o_held
);
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;

  always_comb begin
    cnt_d = 16'h0000;
    if (i_level) begin
      cnt_d = (cnt_q == LIMIT) ? cnt_q : cnt_q + 16'h0001;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt_q  <= 16'h0000;
      o_held <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      o_held <= (cnt_d == LIMIT);
    end
  end
endmodule // ppm_persist

// file: verif/ppm_partner.sv
/*
  ppm_partner: behavioural link partner, seen by the sequencer only as line energy.
  Assumes the bench commands it with one-cycle pulses synchronous to i_mclk.
*/
module ppm_partner #(
  parameter int unsigned PAT_CYC = 25
) (
  input  wire logic i_mclk,
  input  wire logic i_arst_n,
  input  wire logic i_go_quiet,
  input  wire logic i_send_wake,
  output logic      o_energy
);
  timeunit 1ns;
  timeprecision 1ps;

  logic        link_q;
  logic [15:0] pat_q;

  // the wake pattern always runs its full length before link-up starts
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      link_q <= 1'b1;
      pat_q  <= 16'h0000;
    end else if (i_send_wake) begin
      pat_q <= 16'(PAT_CYC);
    end else if (pat_q != 16'h0000) begin
      pat_q <= pat_q - 16'h0001;
      if (pat_q == 16'h0001) link_q <= 1'b1;
    end else if (i_go_quiet) begin
      link_q <= 1'b0;
    end
  end

  assign o_energy = link_q | (pat_q != 16'h0000);
endmodule // ppm_partner

// file: verif/ppm_seq_test.sv
/*
  ppm_seq_test: self-checking bench of the power-mode sequencer with a line partner.
  Assumes short wake and energy-loss counts; the supply switch follows the inhibit output.
*/
module ppm_seq_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int unsigned PAT = 20;
  logic        i_mclk = 1'b0, i_arst_n = 1'b0, i_rst_pin_n = 1'b1, i_supply_ok = 1'b1;
  logic        i_supply_off = 1'b0, i_wake = 1'b1, i_strap_auto = 1'b0, i_strap_master = 1'b1;
  logic        i_reg_wr = 1'b0, i_reg_rd = 1'b0, go_quiet = 1'b0, send_wake = 1'b0, hold_supply = 1'b0;
  logic [15:0] i_reg_addr = 16'h0000, i_reg_wdata = 16'h0000, o_reg_rdata;
  logic        o_reg_ack, o_clkout_en, o_pma_term_en, o_pcs_en, o_pma_en, o_link_en, o_smi_en;
  logic        o_supply_inhibit_out, o_io_hiz, o_analog_en, o_energy_det_en, energy;
  logic [4:0]  o_state;
  int          failures = 0, tests_run = 0;

  ppm_seq #(.WAKE_PAT_CYC(PAT), .EN_LOSS_CYC(PAT)) ppm_seq_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_rst_pin_n(i_rst_pin_n), .i_supply_ok(i_supply_ok), .i_supply_off(i_supply_off), .i_wake(i_wake),
    .i_energy_det(energy), .i_strap_auto(i_strap_auto), .i_strap_master(i_strap_master),
    .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .o_reg_rdata(o_reg_rdata), .o_reg_ack(o_reg_ack), .o_clkout_en(o_clkout_en),
    .o_pma_term_en(o_pma_term_en), .o_pcs_en(o_pcs_en), .o_pma_en(o_pma_en), .o_link_en(o_link_en),
    .o_smi_en(o_smi_en), .o_supply_inhibit_out(o_supply_inhibit_out), .o_io_hiz(o_io_hiz),
    .o_analog_en(o_analog_en), .o_energy_det_en(o_energy_det_en), .o_state(o_state));

  ppm_partner #(.PAT_CYC(PAT + 5)) ppm_partner_i (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
    .i_go_quiet(go_quiet), .i_send_wake(send_wake), .o_energy(energy));

  initial forever #20 i_mclk = ~i_mclk;
  // supplies drop one cycle after inhibit unless a scenario holds them up
  always @(posedge i_mclk) i_supply_off <= o_supply_inhibit_out & ~hold_supply;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  // enables packed as clkout, term, pcs, pma, link, smi, inhibit
  task automatic chk_st(input ppm_pkg::ppm_state_e st, input logic [15:0] en);
    chk(16'(o_state), 16'(st));
    chk(16'({o_clkout_en, o_pma_term_en, o_pcs_en, o_pma_en, o_link_en, o_smi_en, o_supply_inhibit_out}), en);
  endtask

  task automatic wait_st(input ppm_pkg::ppm_state_e st, input int lim, input logic [15:0] en);
    for (int k = 0; k < lim && o_state !== st; k++) step(1);
    chk_st(st, en);
  endtask

  task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] d, input logic ack_exp,
                     input logic [15:0] rd_exp);
    @(posedge i_mclk);
    i_reg_wr    <= wr;
    i_reg_rd    <= ~wr;
    i_reg_addr  <= a;
    i_reg_wdata <= d;
    @(posedge i_mclk);
    i_reg_wr <= 1'b0;
    i_reg_rd <= 1'b0;
    #1;
    chk(16'(o_reg_ack), 16'(ack_exp));
    if (!wr) chk(o_reg_rdata, rd_exp);
  endtask

  task automatic pin_reset;
    @(posedge i_mclk) i_rst_pin_n <= 1'b0;
    step(30);
    chk_st(ppm_pkg::ST_RESET, 16'h0040);
    @(posedge i_mclk) i_rst_pin_n <= 1'b1;
  endtask

  task automatic t_boot;
    chk_st(ppm_pkg::ST_RESET, 16'h0040);
    wait_st(ppm_pkg::ST_STANDBY, 40, 16'h0042);
    acc(1'b0, ppm_pkg::REG_MODE_ADDR, 16'h0000, 1'b1, ppm_pkg::MODE_RST);
    acc(1'b0, 16'h0200, 16'h0000, 1'b1, 16'h0000);
    $display("test boot done");
  endtask

  task automatic t_cmds;
    acc(1'b1, ppm_pkg::REG_CMD_ADDR, 16'h0002, 1'b1, 16'h0000);
    chk_st(ppm_pkg::ST_STANDBY, 16'h0042);
    acc(1'b1, ppm_pkg::REG_CMD_ADDR, ppm_pkg::CMD_GO_NORMAL, 1'b1, 16'h0000);
    chk_st(ppm_pkg::ST_NORMAL, 16'h007E);
    acc(1'b0, ppm_pkg::REG_CMD_ADDR, 16'h0000, 1'b1, 16'h0004);
    acc(1'b1, ppm_pkg::REG_CMD_ADDR, ppm_pkg::CMD_GO_STANDBY, 1'b1, 16'h0000);
    chk_st(ppm_pkg::ST_STANDBY, 16'h0042);
    acc(1'b1, ppm_pkg::REG_MODE_ADDR, 16'h0140, 1'b1, 16'h0000);
    wait_st(ppm_pkg::ST_NORMAL, 2, 16'h007E);
    acc(1'b0, ppm_pkg::REG_MODE_ADDR, 16'h0000, 1'b1, 16'h0140);
    acc(1'b1, ppm_pkg::REG_MODE_ADDR, 16'h0100, 1'b1, 16'h0000);
    acc(1'b1, ppm_pkg::REG_CMD_ADDR, ppm_pkg::CMD_GO_STANDBY, 1'b1, 16'h0000);
    chk_st(ppm_pkg::ST_STANDBY, 16'h0042);
    $display("test commands done");
  endtask

  task automatic t_master_sleep;
    acc(1'b1, ppm_pkg::REG_CMD_ADDR, ppm_pkg::CMD_GO_NORMAL, 1'b1, 16'h0000);
    acc(1'b1, ppm_pkg::REG_MODE_ADDR, 16'h0180, 1'b1, 16'h0000);
    @(posedge i_mclk) go_quiet <= 1'b1;
    @(posedge i_mclk) go_quiet <= 1'b0;
    step(PAT + 10);
    chk_st(ppm_pkg::ST_NORMAL, 16'h007E);
    hold_supply <= 1'b1;
    @(posedge i_mclk) i_wake <= 1'b0;
    wait_st(ppm_pkg::ST_SLP_REQ, 5, 16'h0043);
    step(10);
    chk_st(ppm_pkg::ST_SLP_REQ, 16'h0043);
    @(posedge i_mclk) hold_supply <= 1'b0;
    wait_st(ppm_pkg::ST_SLEEP, 4, 16'h0001);
    chk(16'({o_energy_det_en, o_analog_en, o_io_hiz}), 16'h0004);
    acc(1'b0, ppm_pkg::REG_MODE_ADDR, 16'h0000, 1'b0, 16'h0000);
    @(posedge i_mclk) i_wake <= 1'b1;
    wait_st(ppm_pkg::ST_RESET, 4, 16'h0040);
    wait_st(ppm_pkg::ST_NORMAL, 40, 16'h007E);
    acc(1'b0, ppm_pkg::REG_MODE_ADDR, 16'h0000, 1'b1, ppm_pkg::MODE_RST);
    $display("test master sleep done");
  endtask

  task automatic t_slave_remote;
    @(posedge i_mclk) send_wake <= 1'b1;
    @(posedge i_mclk) send_wake <= 1'b0;
    i_strap_master <= 1'b0;
    pin_reset();
    wait_st(ppm_pkg::ST_STANDBY, 40, 16'h0042);
    acc(1'b1, ppm_pkg::REG_CMD_ADDR, ppm_pkg::CMD_GO_NORMAL, 1'b1, 16'h0000);
    acc(1'b1, ppm_pkg::REG_MODE_ADDR, 16'h0180, 1'b1, 16'h0000);
    @(posedge i_mclk) i_wake <= 1'b0;
    step(8);
    chk_st(ppm_pkg::ST_NORMAL, 16'h007E);
    @(posedge i_mclk) go_quiet <= 1'b1;
    @(posedge i_mclk) go_quiet <= 1'b0;
    wait_st(ppm_pkg::ST_SLP_REQ, PAT + 5, 16'h0043);
    wait_st(ppm_pkg::ST_SLEEP, 4, 16'h0001);
    @(posedge i_mclk) send_wake <= 1'b1;
    @(posedge i_mclk) send_wake <= 1'b0;
    wait_st(ppm_pkg::ST_RESET, PAT + 5, 16'h0040);
    wait_st(ppm_pkg::ST_NORMAL, 40, 16'h007E);
    @(posedge i_mclk) i_wake <= 1'b1;
    $display("test slave remote wake done");
  endtask

  task automatic t_swreset;
    i_strap_auto <= 1'b1;
    acc(1'b1, ppm_pkg::REG_SWRST_ADDR, 16'h8000, 1'b1, 16'h0000);
    step(1);
    chk_st(ppm_pkg::ST_RESET, 16'h0040);
    wait_st(ppm_pkg::ST_STANDBY, 40, 16'h0042);
    pin_reset();
    wait_st(ppm_pkg::ST_NORMAL, 40, 16'h007E);
    @(posedge i_mclk) i_supply_ok <= 1'b0;
    step(3);
    chk(16'({o_io_hiz, o_analog_en}), 16'h0002);
    @(posedge i_mclk) i_supply_ok <= 1'b1;
    wait_st(ppm_pkg::ST_NORMAL, 40, 16'h007E);
    $display("test software reset done");
  endtask

  task automatic stop_test;
    $display("checks=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge i_mclk);
    i_arst_n <= 1'b1;
    step(1);
    t_boot();
    t_cmds();
    t_master_sleep();
    t_slave_remote();
    t_swreset();
    stop_test();
  end

  initial begin
    #100us;
    failures++;
    stop_test();
  end
endmodule // ppm_seq_test
